// file: seq_consts.vh
// constants for the remote command error queue
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH

// ***********************************
// queue geometry
// ***********************************
`define SEQ_DEPTH        20
`define SEQ_CODE_W       16
`define SEQ_DESC_W       8
`define SEQ_DETAIL_W     8
`define SEQ_DESC_MAX     255

// ***********************************
// error codes (16-bit two's complement)
// ***********************************
`define SEQ_CODE_NONE    16'h0000
`define SEQ_CODE_BADCHR  16'hff9b
`define SEQ_CODE_SYNTAX  16'hff9a
`define SEQ_CODE_SEPAR   16'hff99
`define SEQ_CODE_GET     16'hff97
`define SEQ_CODE_XTRAPAR 16'hff94
`define SEQ_CODE_MISPAR  16'hff93
`define SEQ_CODE_TOOLONG 16'hff90
`define SEQ_CODE_UNDEF   16'hff8f
`define SEQ_CODE_EXPBIG  16'hff85
`define SEQ_CODE_OVFL    16'hfebe

// ***********************************
// fixed description indices
// ***********************************
`define SEQ_DESC_NONE    8'h00
`define SEQ_DESC_BADCHR  8'h01
`define SEQ_DESC_SYNTAX  8'h02
`define SEQ_DESC_SEPAR   8'h03
`define SEQ_DESC_GET     8'h04
`define SEQ_DESC_XTRAPAR 8'h05
`define SEQ_DESC_MISPAR  8'h06
`define SEQ_DESC_TOOLONG 8'h07
`define SEQ_DESC_UNDEF   8'h08
`define SEQ_DESC_EXPBIG  8'h09
`define SEQ_DESC_OVFL    8'h0a

// ***********************************
// parser limits
// ***********************************
`define SEQ_HDR_MAX      12
`define SEQ_EXP_MAX      32759

// ***********************************
// detector bit positions
// ***********************************
`define SEQ_DET_BADCHR   0
`define SEQ_DET_SYNTAX   1
`define SEQ_DET_SEPAR    2
`define SEQ_DET_GET      3
`define SEQ_DET_XTRAPAR  4
`define SEQ_DET_MISPAR   5
`define SEQ_DET_TOOLONG  6
`define SEQ_DET_UNDEF    7
`define SEQ_DET_EXPBIG   8
`define SEQ_DET_N        9

`endif

// file: seq_store.v
// storage array and pointers of the error queue
`timescale 1ns/100ps
`include "seq_consts.vh"

module seq_store #(
    parameter DEPTH = `SEQ_DEPTH,
    parameter W     = 32,
    parameter AW    = 5
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          clr,
    input  wire          wr,
    input  wire [W-1:0]  wdata,
    input  wire          ovr,
    input  wire [W-1:0]  odata,
    input  wire          rd,
    output wire [W-1:0]  rdata,
    output wire [AW:0]   count,
    output wire          empty,
    output wire          full
);

    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] rp_ff;
    reg [AW-1:0] wp_ff;
    reg [AW:0]   cnt_ff;
    reg [AW-1:0] nxt_rp;
    reg [AW-1:0] nxt_wp;
    reg [AW:0]   nxt_cnt;
    reg [AW-1:0] last;
    wire         do_rd;
    wire         do_wr;

    assign empty = (cnt_ff == {(AW+1){1'b0}});
    assign full  = (cnt_ff == DEPTH[AW:0]);
    assign count = cnt_ff;
    assign rdata = mem[rp_ff];
    assign do_rd = rd & ~empty;
    assign do_wr = wr & (~full | do_rd);

    always @* begin
        nxt_rp  = rp_ff;
        nxt_wp  = wp_ff;
        nxt_cnt = cnt_ff;
        last    = (wp_ff == {AW{1'b0}}) ? DEPTH[AW-1:0] - 1'b1
                                        : wp_ff - 1'b1;
        if (do_rd)
            nxt_rp = (rp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                     : rp_ff + 1'b1;
        if (do_wr)
            nxt_wp = (wp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                     : wp_ff + 1'b1;
        if (do_wr & ~do_rd)
            nxt_cnt = cnt_ff + 1'b1;
        else if (do_rd & ~do_wr)
            nxt_cnt = cnt_ff - 1'b1;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_ff  <= {AW{1'b0}};
            wp_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else if (clr) begin
            rp_ff  <= {AW{1'b0}};
            wp_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            rp_ff  <= nxt_rp;
            wp_ff  <= nxt_wp;
            cnt_ff <= nxt_cnt;
        end
    end

    // array has no reset: the pointers and the count define what is valid
    always @(posedge clk) begin
        if (!clr && do_wr)
            mem[wp_ff] <= wdata;
        else if (!clr && ovr && !empty)
            mem[last] <= odata;
    end

endmodule

// file: seq_error_queue.v
// remote command error queue with parser error detectors
// How it works
// - entries leave in the order they arrived, oldest first
// - a read removes the entry it returns
// - one beep pulse per newly generated error unless beeper disabled
// - a 21st unread error overwrites the newest entry with overflow
// - while overflowed, new errors are dropped until one entry is read
// - reading an empty queue returns code zero, no error
// - clear-status command and power-up empty the queue
// - instrument reset command does not touch the queue
// - every query on a non-empty queue pops and answers exactly one entry
// - answer is signed code plus description, at most 255 characters
// - description index names fixed text; detail byte follows semicolon
// - bad character in header or parameter queues -101
// - malformed syntax queues -102
// - wrong separator queues -103
// - group execute trigger inside a command string queues -105
// - too many parameters queues -108
// - too few parameters queues -109
// - header over 12 characters or long character parameter queues -112
// - unknown or wrongly abbreviated header queues -113
// - exponent above 32759 queues -123
// - device clear leaves queue untouched
`timescale 1ns/100ps
`include "seq_consts.vh"

module seq_error_queue #(
    parameter DEPTH = `SEQ_DEPTH,
    parameter AW    = 5
) (
    input  wire                      clk,
    input  wire                      arst_n,
    input  wire                      beep_en,
    input  wire                      cls_cmd,
    input  wire                      rst_cmd,
    input  wire                      dev_clr,
    input  wire                      bad_char,
    input  wire                      syntax_bad,
    input  wire                      sep_bad,
    input  wire                      get_in_msg,
    input  wire                      in_msg,
    input  wire [3:0]                par_got,
    input  wire [3:0]                par_max,
    input  wire [3:0]                par_min,
    input  wire                      par_check,
    input  wire [7:0]                hdr_len,
    input  wire                      hdr_done,
    input  wire                      chr_par_long,
    input  wire                      hdr_unknown,
    input  wire [15:0]               exp_val,
    input  wire                      exp_done,
    input  wire                      push,
    input  wire [`SEQ_CODE_W-1:0]    push_code,
    input  wire [`SEQ_DESC_W-1:0]    push_desc,
    input  wire [`SEQ_DETAIL_W-1:0]  push_detail,
    input  wire                      query,
    output reg                       resp_valid,
    output reg  [`SEQ_CODE_W-1:0]    resp_code,
    output reg  [`SEQ_DESC_W-1:0]    resp_desc,
    output reg  [`SEQ_DETAIL_W-1:0]  resp_detail,
    output reg  [7:0]                resp_len_max,
    output reg                       beep,
    output wire [AW:0]               err_count,
    output reg                       ovfl
);

    localparam EW = `SEQ_CODE_W + `SEQ_DESC_W + `SEQ_DETAIL_W;

    // ***********************************
    // reset release
    // ***********************************
    reg rs0_ff;
    reg rs1_ff;
    wire rst_n;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs0_ff <= 1'b0;
            rs1_ff <= 1'b0;
        end else begin
            rs0_ff <= 1'b1;
            rs1_ff <= rs0_ff;
        end
    end
    assign rst_n = rs1_ff;

    // ***********************************
    // detectors
    // ***********************************
    wire [`SEQ_DET_N-1:0] det;

    assign det[`SEQ_DET_BADCHR]  = bad_char;
    assign det[`SEQ_DET_SYNTAX]  = syntax_bad;
    assign det[`SEQ_DET_SEPAR]   = sep_bad;
    assign det[`SEQ_DET_GET]     = get_in_msg & in_msg;
    assign det[`SEQ_DET_XTRAPAR] = par_check & (par_got > par_max);
    assign det[`SEQ_DET_MISPAR]  = par_check & (par_got < par_min);
    assign det[`SEQ_DET_TOOLONG] = (hdr_done &
                   (hdr_len > 8'd`SEQ_HDR_MAX)) | chr_par_long;
    assign det[`SEQ_DET_UNDEF]   = hdr_unknown;
    assign det[`SEQ_DET_EXPBIG]  = exp_done &
                   (exp_val > 16'd`SEQ_EXP_MAX);

    // lowest bit wins when several detectors fire together; the rest
    // would be lost, so the parser should only raise one per cycle
    reg                     det_push;
    reg [`SEQ_CODE_W-1:0]   det_code;
    reg [`SEQ_DESC_W-1:0]   det_desc;

    always @* begin
        det_push = 1'b1;
        det_code = `SEQ_CODE_NONE;
        det_desc = `SEQ_DESC_NONE;
        if (det[`SEQ_DET_BADCHR]) begin
            det_code = `SEQ_CODE_BADCHR;
            det_desc = `SEQ_DESC_BADCHR;
        end else if (det[`SEQ_DET_SYNTAX]) begin
            det_code = `SEQ_CODE_SYNTAX;
            det_desc = `SEQ_DESC_SYNTAX;
        end else if (det[`SEQ_DET_SEPAR]) begin
            det_code = `SEQ_CODE_SEPAR;
            det_desc = `SEQ_DESC_SEPAR;
        end else if (det[`SEQ_DET_GET]) begin
            det_code = `SEQ_CODE_GET;
            det_desc = `SEQ_DESC_GET;
        end else if (det[`SEQ_DET_XTRAPAR]) begin
            det_code = `SEQ_CODE_XTRAPAR;
            det_desc = `SEQ_DESC_XTRAPAR;
        end else if (det[`SEQ_DET_MISPAR]) begin
            det_code = `SEQ_CODE_MISPAR;
            det_desc = `SEQ_DESC_MISPAR;
        end else if (det[`SEQ_DET_TOOLONG]) begin
            det_code = `SEQ_CODE_TOOLONG;
            det_desc = `SEQ_DESC_TOOLONG;
        end else if (det[`SEQ_DET_UNDEF]) begin
            det_code = `SEQ_CODE_UNDEF;
            det_desc = `SEQ_DESC_UNDEF;
        end else if (det[`SEQ_DET_EXPBIG]) begin
            det_code = `SEQ_CODE_EXPBIG;
            det_desc = `SEQ_DESC_EXPBIG;
        end else begin
            det_push = 1'b0;
        end
    end

    // ***********************************
    // push selection
    // ***********************************
    // detectors take priority over the external push port
    wire                 any_err;
    wire [EW-1:0]        new_entry;

    assign any_err   = det_push | push;
    assign new_entry = det_push ?
        {det_code, det_desc, {`SEQ_DETAIL_W{1'b0}}} :
        {push_code, push_desc, push_detail};

    // ***********************************
    // queue
    // ***********************************
    wire [EW-1:0]  q_rdata;
    wire           q_empty;
    wire           q_full;
    wire           pop;
    wire           wr_en;
    wire           ovr_en;
    wire           clr;
    reg            ovfl_ff;
    reg            nxt_ovfl;

    // dev_clr and rst_cmd intentionally have no path to clr
    assign clr    = cls_cmd;
    assign pop    = query & ~q_empty;
    // full with no pop: the newest slot is rewritten, not appended
    assign wr_en  = any_err & ~ovfl_ff & (~q_full | pop);
    assign ovr_en = any_err & ~ovfl_ff & q_full & ~pop;
    always @* begin
        nxt_ovfl = ovfl_ff;
        if (pop)
            nxt_ovfl = 1'b0;
        else if (ovr_en)
            nxt_ovfl = 1'b1;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ovfl_ff <= 1'b0;
        else if (clr)
            ovfl_ff <= 1'b0;
        else
            ovfl_ff <= nxt_ovfl;
    end

    seq_store #(
        .DEPTH (DEPTH),
        .W     (EW),
        .AW    (AW)
    ) u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (clr),
        .wr    (wr_en),
        .wdata (new_entry),
        .ovr   (ovr_en),
        .odata ({`SEQ_CODE_OVFL, `SEQ_DESC_OVFL,
                 {`SEQ_DETAIL_W{1'b0}}}),
        .rd    (pop),
        .rdata (q_rdata),
        .count (err_count),
        .empty (q_empty),
        .full  (q_full)
    );

    // ***********************************
    // answer and beeper
    // ***********************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid   <= 1'b0;
            resp_code    <= `SEQ_CODE_NONE;
            resp_desc    <= `SEQ_DESC_NONE;
            resp_detail  <= {`SEQ_DETAIL_W{1'b0}};
            resp_len_max <= 8'h00;
            beep         <= 1'b0;
            ovfl         <= 1'b0;
        end else begin
            resp_valid   <= query;
            resp_len_max <= 8'd`SEQ_DESC_MAX;
            if (query && q_empty) begin
                resp_code   <= `SEQ_CODE_NONE;
                resp_desc   <= `SEQ_DESC_NONE;
                resp_detail <= {`SEQ_DETAIL_W{1'b0}};
            end else if (query) begin
                resp_code   <= q_rdata[EW-1 -: `SEQ_CODE_W];
                resp_desc   <= q_rdata[`SEQ_DETAIL_W +: `SEQ_DESC_W];
                resp_detail <= q_rdata[`SEQ_DETAIL_W-1:0];
            end
            // beeps even for errors dropped in overflow: each was generated
            beep <= any_err & beep_en;
            ovfl <= nxt_ovfl & ~clr;
        end
    end

endmodule

// file: seq_error_queue_properties.sv
// assertion checker watching the error queue ports
`timescale 1ns/100ps
module seq_error_queue_properties #(
    parameter DEPTH = 20,
    parameter AW    = 5
) (
    input wire          clk,
    input wire          arst_n,
    input wire          beep_en,
    input wire          cls_cmd,
    input wire          rst_cmd,
    input wire          dev_clr,
    input wire          push,
    input wire          query,
    input wire          resp_valid,
    input wire [15:0]   resp_code,
    input wire [7:0]    resp_len_max,
    input wire          beep,
    input wire [AW:0]   err_count,
    input wire          ovfl
);
    // ***********************************
    // properties
    // ***********************************
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_lone_push;
        push && !query && !cls_cmd;
    endsequence
    sequence s_full_push;
        s_lone_push ##0 (err_count == DEPTH && !ovfl);
    endsequence

    property p_answer; query |=> resp_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_stray; !query |=> !resp_valid; endproperty
    a_stray: assert property (p_stray) else $error("stray answer");
    property p_empty;
        query && !push && err_count == 0 |=> resp_code == 16'h0000;
    endproperty
    a_empty: assert property (p_empty) else $error("empty read");
    property p_pop;
        query && !push && err_count != 0
            |=> err_count == $past(err_count) - 1'b1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop count");
    property p_push;
        s_lone_push ##0 (err_count < DEPTH && !ovfl)
            |=> err_count == $past(err_count) + 1'b1;
    endproperty
    a_push: assert property (p_push) else $error("push count");
    property p_full; s_full_push |=> ovfl && err_count == DEPTH; endproperty
    a_full: assert property (p_full) else $error("overflow");
    property p_drop; ovfl ##0 s_lone_push |=> ovfl && $stable(err_count);
    endproperty
    a_drop: assert property (p_drop) else $error("not dropped");
    property p_clear; cls_cmd |=> err_count == 0 && !ovfl; endproperty
    a_clear: assert property (p_clear) else $error("not cleared");
    property p_keep;
        (rst_cmd || dev_clr) && !push && !query && !cls_cmd
            |=> $stable(err_count);
    endproperty
    a_keep: assert property (p_keep) else $error("queue touched");
    property p_beep; push |=> beep == $past(beep_en); endproperty
    a_beep: assert property (p_beep) else $error("beep");
    property p_len; resp_valid |-> resp_len_max == 8'hff; endproperty
    a_len: assert property (p_len) else $error("length limit");
endmodule

bind seq_error_queue seq_error_queue_properties #(.DEPTH(DEPTH), .AW(AW))
    chk_inst (.clk(clk), .arst_n(arst_n), .beep_en(beep_en),
    .cls_cmd(cls_cmd), .rst_cmd(rst_cmd), .dev_clr(dev_clr), .push(push),
    .query(query), .resp_valid(resp_valid), .resp_code(resp_code),
    .resp_len_max(resp_len_max), .beep(beep), .err_count(err_count),
    .ovfl(ovfl));

// file: seq_host_model.sv
// remote host model issuing error queries and taking the answers
`timescale 1ns/100ps
module seq_host_model (
    input  wire         clk,
    input  wire         ask,
    output reg          query,
    input  wire         resp_valid,
    input  wire [15:0]  resp_code,
    output reg  [15:0]  got_code
);
    initial query = 1'b0;
    initial got_code = 16'h5a5a;
    // one query per request; answer taken only in its valid cycle
    always @(posedge clk) begin
        query <= ask;
        if (resp_valid) begin
            got_code <= resp_code;
        end
    end
endmodule

// file: testbench.sv
// self-checking bench for the error queue
`timescale 1ns/100ps
`include "seq_consts.vh"
module testbench;
    reg          clk = 1'b0;
    reg          arst_n = 1'b0;
    reg          beep_en = 1'b1;
    reg          cls_cmd = 1'b0;
    reg          rst_cmd = 1'b0;
    reg          dev_clr = 1'b0;
    reg  [9:0]   det = 10'h000;
    reg          bnd = 1'b0;
    reg          push = 1'b0;
    reg  [15:0]  push_code = 16'h0000;
    reg  [7:0]   push_desc = 8'h00;
    reg  [7:0]   push_detail = 8'h00;
    reg          ask = 1'b0;
    wire         query, resp_valid, beep, ovfl;
    wire [15:0]  resp_code, got_code;
    wire [7:0]   resp_desc, resp_detail, resp_len_max;
    wire [5:0]   err_count;
    integer      miscompares = 0;
    integer      check_count = 0;
    integer      cyc = 0;
    integer      i;

    // code expected from detector pulse k; 6 and 9 both mean too long
    function [15:0] exp_code(input integer k);
        case (k)
            0: exp_code = `SEQ_CODE_BADCHR;
            1: exp_code = `SEQ_CODE_SYNTAX;
            2: exp_code = `SEQ_CODE_SEPAR;
            3: exp_code = `SEQ_CODE_GET;
            4: exp_code = `SEQ_CODE_XTRAPAR;
            5: exp_code = `SEQ_CODE_MISPAR;
            7: exp_code = `SEQ_CODE_UNDEF;
            8: exp_code = `SEQ_CODE_EXPBIG;
            default: exp_code = `SEQ_CODE_TOOLONG;
        endcase
    endfunction

    always #10 clk = ~clk;

    // bnd turns the GET, parameter-count, header-length and exponent inputs into their just-legal values
    seq_error_queue seq_error_queue_inst (.clk(clk), .arst_n(arst_n),
        .beep_en(beep_en), .cls_cmd(cls_cmd), .rst_cmd(rst_cmd),
        .dev_clr(dev_clr), .bad_char(det[0]), .syntax_bad(det[1]),
        .sep_bad(det[2]), .get_in_msg(det[3]), .in_msg(!bnd),
        .par_got(det[5] ? (bnd ? 4'h1 : 4'h0) : (bnd ? 4'h3 : 4'h4)),
        .par_max(4'h3), .par_min(4'h1),
        .par_check(det[4] | det[5]), .hdr_len(bnd ? 8'h0c : 8'h0d),
        .hdr_done(det[6]), .chr_par_long(det[9]), .hdr_unknown(det[7]),
        .exp_val(bnd ? 16'h7ff7 : 16'h7ff8), .exp_done(det[8]),
        .push(push), .push_code(push_code), .push_desc(push_desc),
        .push_detail(push_detail), .query(query), .resp_valid(resp_valid),
        .resp_code(resp_code), .resp_desc(resp_desc),
        .resp_detail(resp_detail), .resp_len_max(resp_len_max),
        .beep(beep), .err_count(err_count), .ovfl(ovfl));

    seq_host_model seq_host_model_inst (.clk(clk), .ask(ask), .query(query),
        .resp_valid(resp_valid), .resp_code(resp_code), .got_code(got_code));

    // ***********************************
    // helpers
    // ***********************************
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count = check_count + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task put(input [15:0] c, input [7:0] d);
        @(posedge clk);
        push <= 1'b1; push_code <= c; push_desc <= d; push_detail <= ~d;
        @(posedge clk);
        push <= 1'b0;
        #1;
    endtask
    // answer lands one edge after the model raises query, got_code one edge later
    task rd(input [15:0] c, input [7:0] d);
        @(posedge clk);
        ask <= 1'b1;
        @(posedge clk);
        ask <= 1'b0;
        tick(2);
        #1;
        chk("code", c, got_code);
        chk("desc", d, resp_desc);
    endtask
    task complete_run;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ***********************************
    // scenarios
    // ***********************************
    task t_fifo;
        for (i = 0; i < 3; i++) put(16'hfe00 + i, 8'h20 + i);
        chk("count", 3, err_count);
        chk("beep", 1, beep);
        rd(16'hfe00, 8'h20);
        chk("detail", 8'hdf, resp_detail);
        chk("len", 8'hff, resp_len_max);
        rd(16'hfe01, 8'h21);
        rd(16'hfe02, 8'h22);
        rd(`SEQ_CODE_NONE, `SEQ_DESC_NONE);
        $display("test fifo done");
    endtask
    task t_det;
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            det <= 10'h001 << i;
            @(posedge clk);
            det <= 10'h000;
            rd(exp_code(i), i < 9 ? i[7:0] + 8'h01 : `SEQ_DESC_TOOLONG);
        end
        @(posedge clk);
        bnd <= 1'b1;
        det <= 10'h168;
        @(posedge clk);
        det <= 10'h010;
        @(posedge clk);
        det <= 10'h000;
        bnd <= 1'b0;
        tick(2);
        #1;
        chk("count", 0, err_count);
        $display("test detectors done");
    endtask
    task t_ovfl;
        for (i = 0; i < 22; i++) put(16'hfd00 + i, 8'h40);
        chk("ovfl", 1, ovfl);
        chk("count", 20, err_count);
        rd(16'hfd00, 8'h40);
        put(16'hfc00, 8'h41);
        chk("count", 20, err_count);
        for (i = 1; i < 19; i++) rd(16'hfd00 + i, 8'h40);
        rd(`SEQ_CODE_OVFL, `SEQ_DESC_OVFL);
        rd(16'hfc00, 8'h41);
        $display("test overflow done");
    endtask
    task t_cmd;
        put(16'hfb00, 8'h50);
        @(posedge clk);
        rst_cmd <= 1'b1;
        @(posedge clk);
        rst_cmd <= 1'b0;
        dev_clr <= 1'b1;
        ask <= 1'b1;
        @(posedge clk);
        dev_clr <= 1'b0;
        ask <= 1'b0;
        push <= 1'b1;
        push_code <= 16'hfb01;
        @(posedge clk);
        push <= 1'b0;
        tick(1);
        #1;
        chk("code", 16'hfb00, got_code);
        chk("count", 1, err_count);
        @(posedge clk);
        cls_cmd <= 1'b1;
        @(posedge clk);
        cls_cmd <= 1'b0;
        #1;
        chk("count", 0, err_count);
        $display("test commands done");
    endtask
    task t_beep;
        @(posedge clk);
        beep_en <= 1'b0;
        put(16'hfa00, 8'h60);
        chk("beep", 0, beep);
        @(posedge clk);
        beep_en <= 1'b1;
        rd(16'hfa00, 8'h60);
        $display("test beeper done");
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end

    initial begin
        tick(5);
        arst_n <= 1'b1;
        tick(3);
        t_fifo;
        t_det;
        t_ovfl;
        t_cmd;
        t_beep;
        complete_run;
    end
endmodule
